/* File: logic/quh_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef QUH_MAP_SVH
`define QUH_MAP_SVH
// ---------------------------------------------------------------
// register offsets within one channel
// ---------------------------------------------------------------
`define QUH_ADR_DATA   3'h0
`define QUH_ADR_IEN    3'h1
`define QUH_ADR_ISTAT  3'h2
`define QUH_ADR_LCTL   3'h3
`define QUH_ADR_MCTL   3'h4
`define QUH_ADR_LSTAT  3'h5
`define QUH_ADR_MSTAT  3'h6
`define QUH_ADR_SCR    3'h7
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define QUH_FIFO_EN    0
`define QUH_FIFO_RXCLR 1
`define QUH_FIFO_TXCLR 2
`define QUH_FIFO_BLK   3
`define QUH_MODEM_IRQ  3
`define QUH_LINE_DLAB  7
`define QUH_IEN_RX     0
`define QUH_IEN_TX     1
// ---------------------------------------------------------------
// reset values, depths and trigger levels
// ---------------------------------------------------------------
`define QUH_REG_RST    8'h00
`define QUH_MSTAT_VAL  8'h00
`define QUH_FIFO_DEPTH 5'h10
`define QUH_TX_TRIG    5'h08
`define QUH_RX_TRIG0   5'h01
`define QUH_RX_TRIG1   5'h04
`define QUH_RX_TRIG2   5'h08
`define QUH_RX_TRIG3   5'h0e
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define QUH_CLK_NS     25
`define QUH_RST_MIN_NS 40
`define QUH_RST_CYC    ((`QUH_RST_MIN_NS + `QUH_CLK_NS - 1) / `QUH_CLK_NS)
`endif

/* File: logic/quh_pkg.sv */
// types shared by the host port design
package quh_pkg;
    typedef logic [7:0] quh_byte_type;
    typedef enum logic [0:0] {
        QUH_TX_IDLE  = 1'b0,
        QUH_TX_SHIFT = 1'b1
    } quh_tx_state_type;
endpackage : quh_pkg

/* File: logic/quh_host_port.sv */
// four-channel uart host port with channel select, registers, fifos and irq outputs
`timescale 1ns/1ps
`include "quh_map.svh"

module quh_host_port
    import quh_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             reset_pin,
    // mode straps
    input  wire logic             bus_mode,
    input  wire logic             irq_style_select,
    // strobe style bus
    input  wire logic             chan_a_sel_n,
    input  wire logic             chan_b_sel_n,
    input  wire logic             chan_c_sel_n,
    input  wire logic             chan_d_sel_n,
    input  wire logic             read_strobe_n,
    input  wire logic             write_strobe_n,
    // read/write line bus
    input  wire logic             single_sel_n,
    input  wire logic             rw_dir,
    input  wire logic             chan_addr_hi,
    input  wire logic             chan_addr_lo,
    // shared address and data
    input  wire logic [2:0]       reg_addr,
    input  wire logic [7:0]       data_in,
    output logic      [7:0]       data_out,
    output logic                  data_oe,
    // serial side
    input  wire logic [3:0]       rx_valid,
    input  wire logic [3:0][7:0]  rx_byte,
    output logic      [3:0]       tx_out,
    output logic      [3:0]       irq_out,
    output logic      [3:0]       irq_oe
);

    default clocking qcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ---------------------------------------------------------------
    // reset pin qualification
    // ---------------------------------------------------------------
    logic       pin_act;
    logic [1:0] rst_cnt;
    logic       res;

    // pin polarity follows bus mode
    assign pin_act = bus_mode ? reset_pin : ~reset_pin;

    // count samples the pin stays active, fire once the minimum is met
    always_ff @(posedge ref_clk) begin
        if (rst || !pin_act) begin
            rst_cnt <= 2'h0;
        end else if (rst_cnt != 2'(`QUH_RST_CYC)) begin
            rst_cnt <= rst_cnt + 2'h1;
        end
    end
    assign res = rst | (rst_cnt == 2'(`QUH_RST_CYC));

    // ---------------------------------------------------------------
    // channel select and access detection
    // ---------------------------------------------------------------
    logic [3:0] sel;
    logic       rd_lvl;
    logic       wr_lvl;
    logic       rd_q;
    logic       wr_q;
    logic       rd_go;
    logic       wr_go;

    // unconnected mode input pulls high, so strobe decode is the default
    always_comb begin
        if (bus_mode) begin
            // low selects pick their channels, all low picks all four
            sel = ~{chan_d_sel_n, chan_c_sel_n, chan_b_sel_n, chan_a_sel_n};
        end else if (single_sel_n) begin
            sel = 4'h0;
        end else begin
            sel = 4'h1 << {chan_addr_hi, chan_addr_lo};
        end
    end

    // access levels from strobes or direction line, no baud clock involved
    assign rd_lvl = (|sel) & (bus_mode ? ~read_strobe_n : rw_dir);
    assign wr_lvl = (|sel) & (bus_mode ? ~write_strobe_n : ~rw_dir);
    assign rd_go  = rd_lvl & ~rd_q;
    assign wr_go  = wr_lvl & ~wr_q;

    // previous access levels for start detection
    always_ff @(posedge ref_clk) begin
        if (res) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_lvl;
            wr_q <= wr_lvl;
        end
    end

    // receive trigger level decode
    function automatic logic [4:0] rx_trig(input logic [1:0] lvl);
        unique case (lvl)
            2'h0: rx_trig = `QUH_RX_TRIG0;
            2'h1: rx_trig = `QUH_RX_TRIG1;
            2'h2: rx_trig = `QUH_RX_TRIG2;
            2'h3: rx_trig = `QUH_RX_TRIG3;
        endcase
    endfunction : rx_trig

    // ---------------------------------------------------------------
    // per-channel register set, fifos, baud and transmit engine
    // ---------------------------------------------------------------
    quh_byte_type ch_rdata [4];
    logic [3:0]   ch_irq;
    logic [3:0]   ch_oe;
    logic [3:0]   ch_txd;

    for (genvar g = 0; g < 4; g++) begin : ch
        quh_byte_type     irq_enable_reg, fifo_control_reg, line_control_reg;
        quh_byte_type     modem_control_reg, scratch_reg, divisor_low, divisor_high;
        quh_byte_type     rd, irq_status_reg, line_status_reg;
        quh_byte_type     txm [16];
        quh_byte_type     rxm [16];
        logic [3:0]       tx_wp, tx_rp, rx_wp, rx_rp, sub, nbit;
        logic [4:0]       tx_cnt, rx_cnt, cap;
        logic [15:0]      bcnt;
        logic [9:0]       sh;
        logic             wr_me, rd_me, dlab, fifo_on, tx_clr, rx_clr;
        logic             tx_push, tx_pop, rx_push, rx_pop, tick, bit_tick;
        logic             txd, ovr, tx_lvl, rx_lvl, rx_i, tx_i;
        quh_tx_state_type st;

        // only the channel selected in this cycle sees the access
        assign wr_me   = wr_go & sel[g];
        assign rd_me   = rd_go & sel[g];
        assign dlab    = line_control_reg[`QUH_LINE_DLAB];
        assign fifo_on = fifo_control_reg[`QUH_FIFO_EN];
        assign cap     = fifo_on ? `QUH_FIFO_DEPTH : 5'h01;
        assign tx_clr  = wr_me & (reg_addr == `QUH_ADR_ISTAT) & data_in[`QUH_FIFO_TXCLR];
        assign rx_clr  = wr_me & (reg_addr == `QUH_ADR_ISTAT) & data_in[`QUH_FIFO_RXCLR];
        assign tx_push = wr_me & (reg_addr == `QUH_ADR_DATA) & ~dlab & (tx_cnt < cap);
        assign tx_pop  = (st == QUH_TX_IDLE) & (tx_cnt != 5'h00);
        // receive input is ignored while reset is held
        assign rx_push = rx_valid[g] & ~res & (rx_cnt < cap);
        assign rx_pop  = rd_me & (reg_addr == `QUH_ADR_DATA) & ~dlab & (rx_cnt != 5'h00);

        // software registers of this channel
        always_ff @(posedge ref_clk) begin
            if (res) begin
                irq_enable_reg    <= `QUH_REG_RST;
                fifo_control_reg  <= `QUH_REG_RST;
                line_control_reg  <= `QUH_REG_RST;
                modem_control_reg <= `QUH_REG_RST;
                scratch_reg       <= `QUH_REG_RST;
                divisor_low       <= `QUH_REG_RST;
                divisor_high      <= `QUH_REG_RST;
            end else if (wr_me) begin
                unique case (reg_addr)
                    `QUH_ADR_DATA:  if (dlab) divisor_low <= data_in;
                    `QUH_ADR_IEN: begin
                        if (dlab) divisor_high <= data_in;
                        else irq_enable_reg <= data_in;
                    end
                    `QUH_ADR_ISTAT: fifo_control_reg <= data_in;
                    `QUH_ADR_LCTL:  line_control_reg <= data_in;
                    `QUH_ADR_MCTL:  modem_control_reg <= data_in;
                    `QUH_ADR_SCR:   scratch_reg <= data_in;
                    default:        ;
                endcase
            end
        end

        // transmit fifo
        always_ff @(posedge ref_clk) begin
            if (res || tx_clr) begin
                tx_wp  <= 4'h0;
                tx_rp  <= 4'h0;
                tx_cnt <= 5'h00;
            end else begin
                if (tx_push) begin
                    txm[tx_wp] <= data_in;
                    tx_wp      <= tx_wp + 4'h1;
                end
                if (tx_pop) begin
                    tx_rp <= tx_rp + 4'h1;
                end
                tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
            end
        end

        // receive fifo and overrun flag, a new overrun wins over the line status read clear
        always_ff @(posedge ref_clk) begin
            if (res || rx_clr) begin
                rx_wp  <= 4'h0;
                rx_rp  <= 4'h0;
                rx_cnt <= 5'h00;
                ovr    <= 1'b0;
            end else begin
                if (rx_push) begin
                    rxm[rx_wp] <= rx_byte[g];
                    rx_wp      <= rx_wp + 4'h1;
                end
                if (rx_pop) begin
                    rx_rp <= rx_rp + 4'h1;
                end
                rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
                if (rx_valid[g] && !rx_push) begin
                    ovr <= 1'b1;
                end else if (rd_me && reg_addr == `QUH_ADR_LSTAT) begin
                    ovr <= 1'b0;
                end
            end
        end

        // baud generator, one tick per divisor count, bit every 16 ticks
        always_ff @(posedge ref_clk) begin
            if (res || {divisor_high, divisor_low} == 16'h0000) begin
                bcnt <= 16'h0000;
                tick <= 1'b0;
            end else if (bcnt == {divisor_high, divisor_low} - 16'h0001) begin
                bcnt <= 16'h0000;
                tick <= 1'b1;
            end else begin
                bcnt <= bcnt + 16'h0001;
                tick <= 1'b0;
            end
        end
        always_ff @(posedge ref_clk) begin
            if (res) begin
                sub <= 4'h0;
            end else if (tick) begin
                sub <= sub + 4'h1;
            end
        end
        assign bit_tick = tick & (sub == 4'hf);

        // transmit engine, fixed 8n1 frame, line idles high
        always_ff @(posedge ref_clk) begin
            if (res) begin
                st   <= QUH_TX_IDLE;
                txd  <= 1'b1;
                sh   <= 10'h3ff;
                nbit <= 4'h0;
            end else begin
                unique case (st)
                    QUH_TX_IDLE: begin
                        if (tx_pop) begin
                            sh   <= {1'b1, txm[tx_rp], 1'b0};
                            nbit <= 4'h0;
                            st   <= QUH_TX_SHIFT;
                        end
                    end
                    QUH_TX_SHIFT: begin
                        if (bit_tick) begin
                            txd  <= sh[0];
                            sh   <= {1'b1, sh[9:1]};
                            nbit <= nbit + 4'h1;
                            if (nbit == 4'h9) st <= QUH_TX_IDLE;
                        end
                    end
                endcase
            end
        end

        // interrupt levels per fifo mode, block setting does not change them
        assign tx_lvl = fifo_on ? (tx_cnt < `QUH_TX_TRIG)
                                : (tx_cnt == 5'h00);
        assign rx_lvl = fifo_on ? (rx_cnt >= rx_trig(fifo_control_reg[7:6]))
                                : (rx_cnt != 5'h00);
        assign rx_i   = irq_enable_reg[`QUH_IEN_RX] & rx_lvl;
        assign tx_i   = irq_enable_reg[`QUH_IEN_TX] & tx_lvl;
        assign irq_status_reg  = {{2{fifo_on}}, 3'b000, rx_i, tx_i & ~rx_i, ~(rx_i | tx_i)};
        assign line_status_reg = {1'b0, (tx_cnt == 5'h00) & (st == QUH_TX_IDLE),
                                  tx_cnt == 5'h00, 3'b000, ovr, rx_cnt != 5'h00};

        // this channel's own read decode
        always_comb begin
            rd = `QUH_REG_RST;
            unique case (reg_addr)
                `QUH_ADR_DATA:  rd = dlab ? divisor_low : rxm[rx_rp];
                `QUH_ADR_IEN:   rd = dlab ? divisor_high : irq_enable_reg;
                `QUH_ADR_ISTAT: rd = irq_status_reg;
                `QUH_ADR_LCTL:  rd = line_control_reg;
                `QUH_ADR_MCTL:  rd = modem_control_reg;
                `QUH_ADR_LSTAT: rd = line_status_reg;
                `QUH_ADR_MSTAT: rd = `QUH_MSTAT_VAL;
                `QUH_ADR_SCR:   rd = scratch_reg;
            endcase
        end

        assign ch_rdata[g] = rd;
        assign ch_irq[g]   = rx_i | tx_i;
        // strobe mode with style input low lets modem bit 3 gate the driver
        assign ch_oe[g]    = ~bus_mode | irq_style_select
                             | modem_control_reg[`QUH_MODEM_IRQ];
        assign ch_txd[g]   = txd;
    end

    // ---------------------------------------------------------------
    // shared data bus and registered outputs
    // ---------------------------------------------------------------
    quh_byte_type rd_pick;

    // lowest selected channel answers, broadcast reads are not expected
    always_comb begin
        rd_pick = `QUH_REG_RST;
        for (int i = 3; i >= 0; i--) begin
            if (sel[i]) rd_pick = ch_rdata[i];
        end
    end

    // read data stand the cycle after the read starts, driven one cycle behind the read level
    always_ff @(posedge ref_clk) begin
        if (res) begin
            data_out <= `QUH_REG_RST;
            data_oe  <= 1'b0;
        end else begin
            if (rd_go) data_out <= rd_pick;
            data_oe <= rd_lvl;
        end
    end

    // serial and interrupt outputs
    always_ff @(posedge ref_clk) begin
        if (res) begin
            tx_out  <= 4'hf;
            irq_out <= 4'h0;
            irq_oe  <= 4'h0;
        end else begin
            tx_out  <= ch_txd;
            irq_out <= ch_irq;
            irq_oe  <= ch_oe;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    bus_release_a: assert property (!rd_lvl |=> !data_oe)
        else $error("data bus driven without a read");
    read_data_a: assert property (rd_go |=> data_oe && data_out == $past(rd_pick))
        else $error("read data not presented after read start");
    bcast_sel_a: assert property (bus_mode && !chan_a_sel_n && !chan_b_sel_n &&
        !chan_c_sel_n && !chan_d_sel_n |-> sel == 4'hf)
        else $error("broadcast select missed a channel");
    strobe_sel_a: assert property (bus_mode && !chan_c_sel_n && chan_a_sel_n &&
        chan_b_sel_n && chan_d_sel_n |-> sel == 4'h4)
        else $error("strobe mode select wrong");
    rw_decode_a: assert property (!bus_mode && !single_sel_n && chan_addr_hi &&
        !chan_addr_lo |-> sel == 4'h4)
        else $error("rw mode decode wrong");
    rw_desel_a: assert property (!bus_mode && single_sel_n |=> !data_oe)
        else $error("deselected rw mode drove bus");
    reset_len_a: assert property (pin_act ##1 pin_act |=> res)
        else $error("qualified reset pulse did not reset");
    short_rst_a: assert property (!pin_act ##1 pin_act ##1 !pin_act |-> !res)
        else $error("short reset pulse acted");
    tx_idle_a: assert property (res |=> tx_out == 4'hf)
        else $error("transmit output not high in reset");
    irq_drive_a: assert property (bus_mode && irq_style_select |=> irq_oe == 4'hf)
        else $error("continuous irq not driven");
    rx_nofifo_a: assert property (!ch[0].fifo_on && ch[0].irq_enable_reg[0] &&
        ch[0].rx_cnt != 5'h00 |=> irq_out[0])
        else $error("receive irq missing with byte held");
    tx_fifo_a: assert property (ch[1].fifo_on && ch[1].tx_cnt >= `QUH_TX_TRIG |->
        !ch[1].tx_lvl)
        else $error("transmit irq level high above trigger");

    bcast_wr_c: cover property (wr_go && sel == 4'hf);
    rw_read_c: cover property (!bus_mode && rd_go && sel == 4'h8);
    rx_irq_c: cover property (ch[1].fifo_on && ch[1].rx_lvl);

endmodule : quh_host_port

/* File: tb/quh_host_model.sv */
// host cpu model that drives the shared parallel bus in both bus styles
`timescale 1ns/1ps
module quh_host_model (
    // clock and strap
    input  wire logic       ref_clk,
    input  wire logic       bus_mode,
    // strobe style bus
    output logic [3:0]      sel_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    // read/write line bus
    output logic            single_sel_n,
    output logic            rw_dir,
    output logic            chan_addr_hi,
    output logic            chan_addr_lo,
    // shared address and data
    output logic [2:0]      reg_addr,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out
);
    // idle bus at time zero
    initial begin
        sel_n = 4'hf;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        single_sel_n = 1'b1;
        rw_dir = 1'b1;
        {chan_addr_hi, chan_addr_lo} = 2'h0;
        reg_addr = 3'h0;
        data_in = 8'h00;
    end

    // one access; callers never read with all four selects low
    task automatic access(input logic wr, input logic [3:0] mask, input logic [1:0] chan,
                          input logic [2:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(posedge ref_clk);
        reg_addr <= addr;
        data_in <= wdata;
        {chan_addr_hi, chan_addr_lo} <= chan;
        if (bus_mode) begin
            sel_n <= ~mask;
            read_strobe_n <= wr;
            write_strobe_n <= !wr;
        end else begin
            single_sel_n <= 1'b0;
            rw_dir <= !wr;
        end
        repeat (2) @(posedge ref_clk);
        rdata = data_out; // read data stand from the edge after the start
        sel_n <= 4'hf;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        single_sel_n <= 1'b1;
        data_in <= ~wdata; // released lines stop showing the old byte
        repeat (2) @(posedge ref_clk);
    endtask : access
endmodule : quh_host_model

/* File: tb/quh_host_port_test.sv */
// self-checking testbench for the four-channel host port
`timescale 1ns/1ps
`include "quh_map.svh"
module quh_host_port_test;
    import quh_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            reset_pin = 1'b0;
    logic            bus_mode = 1'b1;
    logic            irq_style_select = 1'b0;
    logic [3:0]      rx_valid = 4'h0;
    logic [3:0][7:0] rx_byte = '0;
    logic [3:0]      sel_n;
    logic            rd_n, wr_n, ssel_n, rw_dir, ahi, alo;
    logic [2:0]      reg_addr;
    quh_byte_type    data_in, data_out, rd;
    logic            data_oe;
    logic [3:0]      tx_out, irq_out, irq_oe;
    int              errors = 0;
    int              samples_checked = 0;
    logic [9:0]      frame = {1'b1, 8'ha5, 1'b0}; // 8n1 frame, start bit first

    always #12.5 ref_clk = ~ref_clk;

    quh_host_model quh_host_model_i (.ref_clk(ref_clk), .bus_mode(bus_mode), .sel_n(sel_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .single_sel_n(ssel_n), .rw_dir(rw_dir),
        .chan_addr_hi(ahi), .chan_addr_lo(alo), .reg_addr(reg_addr), .data_in(data_in),
        .data_out(data_out));

    quh_host_port quh_host_port_i (.ref_clk(ref_clk), .rst(rst), .reset_pin(reset_pin),
        .bus_mode(bus_mode), .irq_style_select(irq_style_select), .chan_a_sel_n(sel_n[0]),
        .chan_b_sel_n(sel_n[1]), .chan_c_sel_n(sel_n[2]), .chan_d_sel_n(sel_n[3]),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .single_sel_n(ssel_n), .rw_dir(rw_dir),
        .chan_addr_hi(ahi), .chan_addr_lo(alo), .reg_addr(reg_addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_out(tx_out), .irq_out(irq_out), .irq_oe(irq_oe));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] m, input logic [1:0] c, input logic [2:0] a,
                      input logic [7:0] d);
        quh_host_model_i.access(1'b1, m, c, a, d, rd);
    endtask : wr

    task automatic rdc(input logic [3:0] m, input logic [1:0] c, input logic [2:0] a,
                       input logic [7:0] e);
        quh_host_model_i.access(1'b0, m, c, a, 8'h00, rd);
        check(rd, e);
    endtask : rdc

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic push_rx(input int g, input logic [7:0] b);
        @(posedge ref_clk);
        rx_valid <= 4'(1 << g);
        rx_byte[g] <= b;
        @(posedge ref_clk);
        rx_valid <= 4'h0;
        rx_byte[g] <= ~b;
    endtask : push_rx

    task automatic summarize;
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // watchdog against a hung access
    initial begin
        #(25 * 5000);
        errors++;
        summarize();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        settle(10);
        check({4'h0, tx_out}, 8'h0f);
        check({3'h0, irq_oe, data_oe}, 8'h00);
        rst <= 1'b0;
        for (int g = 0; g < 4; g++) wr(4'(1 << g), 2'(3 - g), `QUH_ADR_SCR, 8'h10 + 8'(g));
        wr(4'h0, 2'h0, `QUH_ADR_SCR, 8'hee); // no select writes nothing
        for (int g = 0; g < 4; g++) rdc(4'(1 << g), 2'(3 - g), `QUH_ADR_SCR, 8'h10 + 8'(g));
        wr(4'hf, 2'h0, `QUH_ADR_SCR, 8'h5a);
        for (int g = 0; g < 4; g++) rdc(4'(1 << g), 2'h0, `QUH_ADR_SCR, 8'h5a);
        bus_mode <= 1'b0;
        reset_pin <= 1'b1;
        for (int g = 0; g < 4; g++) wr(4'hf, 2'(g), `QUH_ADR_SCR, 8'h20 + 8'(g));
        for (int g = 0; g < 4; g++) rdc(4'hf, 2'(g), `QUH_ADR_SCR, 8'h20 + 8'(g));
        reset_pin <= 1'b0;
        settle(3);
        reset_pin <= 1'b1;
        rdc(4'h0, 2'h1, `QUH_ADR_SCR, 8'h00);
        bus_mode <= 1'b1;
        reset_pin <= 1'b0;
        wr(4'h1, 2'h0, `QUH_ADR_SCR, 8'h77);
        reset_pin <= 1'b1;
        settle(3);
        check({4'h0, tx_out}, 8'h0f);
        reset_pin <= 1'b0;
        rdc(4'h1, 2'h0, `QUH_ADR_SCR, 8'h00);
        // a pulse of one sample is shorter than the minimum and resets nothing
        wr(4'h1, 2'h0, `QUH_ADR_SCR, 8'h3c);
        reset_pin <= 1'b1;
        settle(1);
        reset_pin <= 1'b0;
        rdc(4'h1, 2'h0, `QUH_ADR_SCR, 8'h3c);
        check({4'h0, irq_oe}, 8'h00);
        wr(4'h1, 2'h0, `QUH_ADR_MCTL, 8'h08);
        check({4'h0, irq_oe}, 8'h01);
        irq_style_select <= 1'b1;
        settle(3);
        check({4'h0, irq_oe}, 8'h0f);
        wr(4'h1, 2'h0, `QUH_ADR_IEN, 8'h02);
        check({7'h0, irq_out[0]}, 8'h01);
        // first byte moves on to the stalled shifter, the second stays held
        wr(4'h1, 2'h0, `QUH_ADR_DATA, 8'h55);
        wr(4'h1, 2'h0, `QUH_ADR_DATA, 8'haa);
        check({7'h0, irq_out[0]}, 8'h00);
        wr(4'h1, 2'h0, `QUH_ADR_IEN, 8'h01);
        check({7'h0, irq_out[0]}, 8'h00);
        push_rx(0, 8'hc3);
        settle(3);
        check({7'h0, irq_out[0]}, 8'h01);
        rdc(4'h1, 2'h0, `QUH_ADR_DATA, 8'hc3);
        check({7'h0, irq_out[0]}, 8'h00);
        wr(4'h2, 2'h0, `QUH_ADR_ISTAT, 8'h47);
        wr(4'h2, 2'h0, `QUH_ADR_IEN, 8'h01);
        for (int i = 0; i < 3; i++) push_rx(1, 8'(i));
        settle(3);
        check({7'h0, irq_out[1]}, 8'h00);
        push_rx(1, 8'h03);
        settle(3);
        check({7'h0, irq_out[1]}, 8'h01);
        wr(4'h2, 2'h0, `QUH_ADR_ISTAT, 8'h4f);
        wr(4'h2, 2'h0, `QUH_ADR_IEN, 8'h02);
        check({7'h0, irq_out[1]}, 8'h01);
        for (int i = 0; i < 9; i++) wr(4'h2, 2'h0, `QUH_ADR_DATA, 8'(i));
        check({7'h0, irq_out[1]}, 8'h00);
        // divisor of one on channel C, then one byte out of its serial pin
        wr(4'h4, 2'h0, `QUH_ADR_LCTL, 8'h80);
        wr(4'h4, 2'h0, `QUH_ADR_DATA, 8'h01);
        wr(4'h4, 2'h0, `QUH_ADR_LCTL, 8'h03);
        wr(4'h4, 2'h0, `QUH_ADR_DATA, 8'ha5);
        @(negedge tx_out[2]);
        settle(8);
        for (int k = 0; k < 10; k++) begin
            check({7'h0, tx_out[2]}, {7'h0, frame[k]});
            settle(16);
        end
        summarize();
    end
endmodule : quh_host_port_test
